/* File: rtl/smcc_defs.svh */
// Constants of the servo motor control core.
`ifndef SMCC_DEFS_SVH
`define SMCC_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMCC_CLK_PERIOD_NS 10
`define SMCC_CTRL_PERIOD_NS 1000
`define SMCC_CTRL_CYCLES (`SMCC_CTRL_PERIOD_NS / `SMCC_CLK_PERIOD_NS)
`define SMCC_CTRL_CNT_W 7

// ----------------------------------------------------------------
// Fixed-point scaling: 100 % is 16384, full range about +-199.99 %
// ----------------------------------------------------------------
`define SMCC_PCT_FULL 16'sh4000
`define SMCC_PCT_MAX 16'sh7fff
`define SMCC_PCT_MIN 16'sh8001
`define SMCC_GAIN_SHIFT 8
`define SMCC_PCT_SHIFT 14

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SMCC_ADDR_W 8
`define SMCC_REG_PROP_GAIN 8'h00
`define SMCC_REG_ADJ_TIME 8'h04
`define SMCC_REG_DERIV_GAIN 8'h08
`define SMCC_REG_PHASE_GAIN 8'h0c
`define SMCC_REG_QSP_DECEL 8'h10
`define SMCC_REG_CHOP_SEL 8'h14
`define SMCC_REG_DIR_LIMIT 8'h18
`define SMCC_REG_RATED_VOLT 8'h1c
`define SMCC_REG_CTRL_WORD 8'h20
`define SMCC_REG_RATED_TQ16 8'h24
`define SMCC_REG_MAX_TQ8 8'h28
`define SMCC_REG_STATUS 8'h2c
`define SMCC_REG_TORQUE 8'h30

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define SMCC_RST_PROP_GAIN 16'h0100
`define SMCC_RST_ADJ_TIME 4'h4
`define SMCC_RST_DERIV_GAIN 16'h0000
`define SMCC_RST_PHASE_GAIN 16'h0000
`define SMCC_RST_QSP_DECEL 16'h0010
`define SMCC_RST_RATED_VOLT 16'h3000
`define SMCC_RST_RATED_TQ16 16'h2000
`define SMCC_RST_MAX_TQ8 16'h4000
`define SMCC_CW_QSP_BIT 0
`define SMCC_ST_AT_LIMIT 0
`define SMCC_ST_QSP 1
`define SMCC_ST_FIELD_WEAK 2
`define SMCC_ST_CHOP16 3
`define SMCC_ST_CUR_LIMIT 4
`define SMCC_ST_TORQUE_MODE 5

`endif

/* File: rtl/smcc_pkg.sv */
// Types shared by the servo motor control core.
package smcc_pkg;

  typedef logic signed [15:0] smcc_pct_t;

  typedef enum logic [1:0] {
    SMCC_CHOP_AUTO = 2'b00,
    SMCC_CHOP_8K = 2'b01,
    SMCC_CHOP_16K = 2'b10,
    SMCC_CHOP_RSVD = 2'b11
  } smcc_chop_t;

  typedef enum logic [1:0] {
    SMCC_DIR_BOTH = 2'b00,
    SMCC_DIR_CW = 2'b01,
    SMCC_DIR_CCW = 2'b10,
    SMCC_DIR_RSVD = 2'b11
  } smcc_dir_t;

endpackage : smcc_pkg

/* File: rtl/smcc_core.sv */
// Servo motor control core logic.
`timescale 1ns/100ps
`include "smcc_defs.svh"

// Behaviour
// RULE_01: Cap torque at upper limit input.
// RULE_02: Bound torque below by lower limit input.
// RULE_03: Upper limit positive, lower limit negative; the code applies both limit inputs as given, with any sign.
// RULE_04: Quick stop ignores external torque limits.
// RULE_05: Speed controller is ideal PID.
// RULE_06: Flag high when controller saturates torque.
// RULE_07: Integral load adopts integral set value.
// RULE_08: Switch high selects torque control.
// RULE_09: Controller one enforces upper speed limit.
// RULE_10: Controller two enforces lower speed limit.
// RULE_11: Clamp setpoint to 100%, direction limit.
// RULE_12: Phase output added to speed setpoint.
// RULE_13: Phase gain, adaptation, symmetric limit.
// RULE_14: Phase control needs limit, enable, gain.
// RULE_15: Quick stop from input or control word.
// RULE_16: Quick stop forces speed control.
// RULE_17: Quick stop ramps speed to zero.
// RULE_18: Quick stop activates phase controller.
// RULE_19: Field weakening on overvoltage or bus limit.
// RULE_20: Excitation scaled by field-weakening input.
// RULE_21: Chopping select: auto, 8 kHz, 16 kHz.
// RULE_22: Auto chopping by torque thresholds.
// RULE_23: Speed mode adds torque within limits.
// RULE_24: Evaluate once per fixed control cycle.
module smcc_core (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`SMCC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [15:0] speed_setpoint_in,
  input wire logic signed [15:0] additional_torque_in,
  input wire logic signed [15:0] lower_torque_limit_in,
  input wire logic signed [15:0] upper_torque_limit_in,
  input wire logic signed [15:0] phase_diff_in,
  input wire logic signed [15:0] phase_limit_in,
  input wire logic signed [15:0] lower_speed_limit_in,
  input wire logic signed [15:0] field_weakening_in,
  input wire logic signed [15:0] integral_set_in,
  input wire logic signed [15:0] phase_gain_adapt_in,
  input wire logic signed [15:0] actual_speed_in,
  input wire logic signed [15:0] output_voltage_in,
  input wire logic voltage_headroom_lost_in,
  input wire logic phase_enable_in,
  input wire logic speed_torque_switch_in,
  input wire logic quick_stop_in,
  input wire logic integral_load_in,
  output logic signed [15:0] torque_setpoint_out,
  output logic signed [15:0] excitation_out,
  output logic signed [15:0] speed_setpoint_out,
  output logic speed_ctrl_at_limit_flag,
  output logic quick_stop_out,
  output logic field_weak_active_out,
  output logic chop_16khz_out,
  output logic current_limit_out,
  output logic ctrl_tick_out
);

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic smcc_pkg::smcc_pct_t sat16(input logic signed [31:0] x);
    if (x > 32'sh7fff)
      sat16 = `SMCC_PCT_MAX;
    else if (x < -32'sh7fff)
      sat16 = `SMCC_PCT_MIN;
    else
      sat16 = x[15:0];
  endfunction : sat16

  function automatic smcc_pkg::smcc_pct_t clamp(input logic signed [15:0] x,
      input logic signed [15:0] lo, input logic signed [15:0] hi);
    if (x > hi)
      clamp = hi;
    else if (x < lo)
      clamp = lo;
    else
      clamp = x;
  endfunction : clamp

  // Signed value times unsigned gain, shifted down.
  function automatic logic signed [31:0] mul_shift(input logic signed [15:0] a,
      input logic [15:0] g, input int sh);
    logic signed [32:0] p;
    p = a * $signed({1'b0, g});
    mul_shift = 32'(p >>> sh);
  endfunction : mul_shift

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [15:0] speed_prop_gain_setting;
  logic [3:0] speed_adjust_time_setting;
  logic [15:0] speed_deriv_gain_setting;
  logic [15:0] phase_gain_setting;
  logic [15:0] quick_stop_decel_setting;
  smcc_pkg::smcc_chop_t chopping_freq_select;
  smcc_pkg::smcc_dir_t direction_limit_setting;
  logic signed [15:0] rated_motor_voltage_setting;
  logic [15:0] device_control_word;
  logic signed [15:0] rated_torque16_setting;
  logic signed [15:0] max_torque8_setting;

  wire wr_prop = reg_wr && reg_addr == `SMCC_REG_PROP_GAIN;
  wire wr_adj = reg_wr && reg_addr == `SMCC_REG_ADJ_TIME;
  wire wr_deriv = reg_wr && reg_addr == `SMCC_REG_DERIV_GAIN;
  wire wr_phase = reg_wr && reg_addr == `SMCC_REG_PHASE_GAIN;
  wire wr_decel = reg_wr && reg_addr == `SMCC_REG_QSP_DECEL;
  wire wr_chop = reg_wr && reg_addr == `SMCC_REG_CHOP_SEL;
  wire wr_dir = reg_wr && reg_addr == `SMCC_REG_DIR_LIMIT;
  wire wr_volt = reg_wr && reg_addr == `SMCC_REG_RATED_VOLT;
  wire wr_cw = reg_wr && reg_addr == `SMCC_REG_CTRL_WORD;
  wire wr_tq16 = reg_wr && reg_addr == `SMCC_REG_RATED_TQ16;
  wire wr_tq8 = reg_wr && reg_addr == `SMCC_REG_MAX_TQ8;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      speed_prop_gain_setting <= `SMCC_RST_PROP_GAIN;
      speed_adjust_time_setting <= `SMCC_RST_ADJ_TIME;
      speed_deriv_gain_setting <= `SMCC_RST_DERIV_GAIN;
      phase_gain_setting <= `SMCC_RST_PHASE_GAIN;
      quick_stop_decel_setting <= `SMCC_RST_QSP_DECEL;
      chopping_freq_select <= smcc_pkg::SMCC_CHOP_AUTO;
      direction_limit_setting <= smcc_pkg::SMCC_DIR_BOTH;
      rated_motor_voltage_setting <= `SMCC_RST_RATED_VOLT;
      device_control_word <= 16'h0000;
      rated_torque16_setting <= `SMCC_RST_RATED_TQ16;
      max_torque8_setting <= `SMCC_RST_MAX_TQ8;
    end
    else
    begin
      if (wr_prop) speed_prop_gain_setting <= reg_wdata[15:0];
      if (wr_adj) speed_adjust_time_setting <= reg_wdata[3:0];
      if (wr_deriv) speed_deriv_gain_setting <= reg_wdata[15:0];
      if (wr_phase) phase_gain_setting <= reg_wdata[15:0];
      if (wr_decel) quick_stop_decel_setting <= reg_wdata[15:0];
      if (wr_chop) chopping_freq_select <= smcc_pkg::smcc_chop_t'(reg_wdata[1:0]);
      if (wr_dir) direction_limit_setting <= smcc_pkg::smcc_dir_t'(reg_wdata[1:0]);
      if (wr_volt) rated_motor_voltage_setting <= reg_wdata[15:0];
      if (wr_cw) device_control_word <= reg_wdata[15:0];
      if (wr_tq16) rated_torque16_setting <= reg_wdata[15:0];
      if (wr_tq8) max_torque8_setting <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Control cycle divider
  // ----------------------------------------------------------------
  logic [`SMCC_CTRL_CNT_W-1:0] cyc_cnt;
  wire tick = cyc_cnt == `SMCC_CTRL_CNT_W'(`SMCC_CTRL_CYCLES - 1);

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      cyc_cnt <= '0;
    else if (tick)
      cyc_cnt <= '0;
    else
      cyc_cnt <= cyc_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // Mode selection and setpoint path
  // ----------------------------------------------------------------
  wire quick_stop = quick_stop_in || device_control_word[`SMCC_CW_QSP_BIT]; // RULE_15
  wire torque_mode = speed_torque_switch_in && !quick_stop; // RULE_08 RULE_16
  wire signed [15:0] full_pos = `SMCC_PCT_FULL;
  wire signed [15:0] full_neg = -`SMCC_PCT_FULL;
  // Direction limit drops a half of the range.
  wire signed [15:0] n_hi = (direction_limit_setting == smcc_pkg::SMCC_DIR_CCW) ?
      16'sh0000 : full_pos;
  wire signed [15:0] n_lo = (direction_limit_setting == smcc_pkg::SMCC_DIR_CW) ?
      16'sh0000 : full_neg;
  wire signed [15:0] nset_lim = clamp(speed_setpoint_in, n_lo, n_hi); // RULE_11

  // Ramp walks to zero during quick stop.
  logic signed [15:0] ramp;
  wire signed [15:0] decel = $signed({1'b0, quick_stop_decel_setting[14:0]});
  wire signed [15:0] ramp_dn = (ramp > decel) ? 16'(ramp - decel) :
      (ramp < -decel) ? 16'(ramp + decel) : 16'sh0000;
  wire signed [15:0] next_ramp = quick_stop ? ramp_dn : nset_lim; // RULE_17

  // ----------------------------------------------------------------
  // Phase controller
  // ----------------------------------------------------------------
  wire phase_on = phase_enable_in || quick_stop; // RULE_18
  wire signed [15:0] adapt_abs = (phase_gain_adapt_in < 0) ?
      sat16(-32'(phase_gain_adapt_in)) : phase_gain_adapt_in;
  wire signed [15:0] ph_gain = sat16(mul_shift(phase_diff_in, phase_gain_setting,
      `SMCC_GAIN_SHIFT));
  wire signed [15:0] ph_adapt = sat16(mul_shift(ph_gain, adapt_abs,
      `SMCC_PCT_SHIFT)); // RULE_13
  // A limit of zero or below switches the controller off, as does a zero gain.
  wire signed [15:0] ph_lim = (phase_limit_in > 0) ? phase_limit_in : 16'sh0000; // RULE_14
  wire signed [15:0] ph_out = phase_on ? clamp(ph_adapt, -ph_lim, ph_lim) : 16'sh0000;
  wire signed [15:0] n_target = sat16(32'(next_ramp) + 32'(ph_out)); // RULE_12

  // ----------------------------------------------------------------
  // Speed controllers (ideal PID)
  // ----------------------------------------------------------------
  logic signed [15:0] integ [2];
  logic signed [15:0] err_prev [2];
  logic signed [15:0] pid_out [2];
  logic signed [15:0] err [2];
  logic signed [15:0] next_integ [2];
  wire signed [15:0] nlim2 = clamp(lower_speed_limit_in, full_neg, full_pos);
  wire signed [15:0] n_ref [2];
  assign n_ref[0] = torque_mode ? nset_lim : n_target; // RULE_09
  assign n_ref[1] = nlim2; // RULE_10

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pid
      wire signed [15:0] e = sat16(32'(n_ref[gi]) - 32'(actual_speed_in));
      wire signed [31:0] p_t = mul_shift(e, speed_prop_gain_setting, `SMCC_GAIN_SHIFT);
      wire signed [15:0] de = sat16(32'(e) - 32'(err_prev[gi]));
      wire signed [31:0] d_t = mul_shift(de, speed_deriv_gain_setting,
          `SMCC_GAIN_SHIFT);
      // Integral step is the proportional term over 2^adjust_time cycles.
      wire signed [15:0] i_sum = sat16(32'(integ[gi]) +
          (p_t >>> speed_adjust_time_setting));
      assign err[gi] = e;
      assign next_integ[gi] = clamp(i_sum, `SMCC_PCT_MIN, `SMCC_PCT_MAX);
      assign pid_out[gi] = sat16(p_t + 32'(next_integ[gi]) + d_t); // RULE_05
    end
  endgenerate

  // ----------------------------------------------------------------
  // Torque demand and limits
  // ----------------------------------------------------------------
  // Quick stop widens the limits to the full range.
  wire signed [15:0] tq_hi = quick_stop ? `SMCC_PCT_MAX : upper_torque_limit_in; // RULE_04
  wire signed [15:0] tq_lo = quick_stop ? `SMCC_PCT_MIN : lower_torque_limit_in; // RULE_04
  wire signed [15:0] m_speed = sat16(32'(pid_out[0]) + 32'(additional_torque_in)); // RULE_23
  // Torque mode: both controllers bound the setpoint.
  wire signed [15:0] m_torque = (additional_torque_in > pid_out[0]) ? pid_out[0] :
      (additional_torque_in < pid_out[1]) ? pid_out[1] : additional_torque_in;
  wire signed [15:0] m_raw = integral_load_in ? integral_set_in :
      torque_mode ? m_torque : m_speed; // RULE_07
  wire signed [15:0] m_set = (m_raw > tq_hi) ? tq_hi : // RULE_01
      (m_raw < tq_lo) ? tq_lo : m_raw; // RULE_02
  wire at_limit = (m_raw > tq_hi) || (m_raw < tq_lo) ||
      (m_raw == `SMCC_PCT_MAX) || (m_raw == `SMCC_PCT_MIN); // RULE_06
  wire signed [15:0] m_abs = (m_set < 0) ? sat16(-32'(m_set)) : m_set;

  // ----------------------------------------------------------------
  // Field weakening and excitation
  // ----------------------------------------------------------------
  wire fw_auto = (output_voltage_in > rated_motor_voltage_setting) ||
      voltage_headroom_lost_in; // RULE_19
  wire signed [15:0] fw_excess = fw_auto ?
      sat16(32'(output_voltage_in) - 32'(rated_motor_voltage_setting)) : 16'sh0000;
  wire signed [15:0] exc_man = clamp(field_weakening_in, 16'sh0000, full_pos); // RULE_20
  wire signed [15:0] exc = clamp(sat16(32'(exc_man) - 32'(fw_excess)), 16'sh0000,
      full_pos);
  // Reduced excitation gives proportionally less torque.
  wire signed [15:0] m_out = sat16(32'((33'(m_set) * 33'(exc)) >>>
      `SMCC_PCT_SHIFT)); // RULE_20

  // ----------------------------------------------------------------
  // Chopping frequency
  // ----------------------------------------------------------------
  wire chop16 = (chopping_freq_select == smcc_pkg::SMCC_CHOP_16K) ||
      (chopping_freq_select != smcc_pkg::SMCC_CHOP_8K &&
      m_abs < rated_torque16_setting); // RULE_21 RULE_22
  wire cur_lim = (chopping_freq_select != smcc_pkg::SMCC_CHOP_8K) &&
      (chopping_freq_select != smcc_pkg::SMCC_CHOP_16K) &&
      (m_abs > max_torque8_setting); // RULE_22

  // ----------------------------------------------------------------
  // Control-cycle state and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ramp <= '0;
      integ[0] <= '0;
      integ[1] <= '0;
      err_prev[0] <= '0;
      err_prev[1] <= '0;
      torque_setpoint_out <= '0;
      excitation_out <= '0;
      speed_setpoint_out <= '0;
      speed_ctrl_at_limit_flag <= 1'b0;
      quick_stop_out <= 1'b0;
      field_weak_active_out <= 1'b0;
      chop_16khz_out <= 1'b0;
      current_limit_out <= 1'b0;
    end
    else if (tick) // RULE_24
    begin
      ramp <= next_ramp;
      integ[0] <= integral_load_in ? integral_set_in : next_integ[0]; // RULE_07
      integ[1] <= torque_mode ? next_integ[1] : 16'sh0000;
      err_prev[0] <= err[0];
      err_prev[1] <= err[1];
      torque_setpoint_out <= m_out;
      excitation_out <= exc;
      speed_setpoint_out <= n_target;
      speed_ctrl_at_limit_flag <= at_limit; // RULE_06
      quick_stop_out <= quick_stop;
      field_weak_active_out <= fw_auto;
      chop_16khz_out <= chop16;
      current_limit_out <= cur_lim;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      ctrl_tick_out <= 1'b0;
    else
      ctrl_tick_out <= tick;
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      `SMCC_REG_PROP_GAIN: rd_mux = {16'h0, speed_prop_gain_setting};
      `SMCC_REG_ADJ_TIME: rd_mux = {28'h0, speed_adjust_time_setting};
      `SMCC_REG_DERIV_GAIN: rd_mux = {16'h0, speed_deriv_gain_setting};
      `SMCC_REG_PHASE_GAIN: rd_mux = {16'h0, phase_gain_setting};
      `SMCC_REG_QSP_DECEL: rd_mux = {16'h0, quick_stop_decel_setting};
      `SMCC_REG_CHOP_SEL: rd_mux = {30'h0, chopping_freq_select};
      `SMCC_REG_DIR_LIMIT: rd_mux = {30'h0, direction_limit_setting};
      `SMCC_REG_RATED_VOLT: rd_mux = {16'h0, rated_motor_voltage_setting};
      `SMCC_REG_CTRL_WORD: rd_mux = {16'h0, device_control_word};
      `SMCC_REG_RATED_TQ16: rd_mux = {16'h0, rated_torque16_setting};
      `SMCC_REG_MAX_TQ8: rd_mux = {16'h0, max_torque8_setting};
      `SMCC_REG_STATUS: rd_mux = {26'h0, torque_mode, current_limit_out,
          chop_16khz_out, field_weak_active_out, quick_stop_out,
          speed_ctrl_at_limit_flag};
      `SMCC_REG_TORQUE: rd_mux = {16'h0, torque_setpoint_out};
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

endmodule : smcc_core

/* File: testbench/smcc_core_monitor.sv */
// Port checker for the servo motor control core.
`timescale 1ns/100ps
module smcc_core_monitor (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic signed [15:0] upper_torque_limit_in,
  input wire logic signed [15:0] lower_torque_limit_in,
  input wire logic signed [15:0] field_weakening_in,
  input wire logic voltage_headroom_lost_in,
  input wire logic phase_enable_in,
  input wire logic quick_stop_in,
  input wire logic signed [15:0] torque_setpoint_out,
  input wire logic signed [15:0] excitation_out,
  input wire logic signed [15:0] speed_setpoint_out,
  input wire logic quick_stop_out,
  input wire logic field_weak_active_out,
  input wire logic chop_16khz_out,
  input wire logic current_limit_out,
  input wire logic ctrl_tick_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Tick spacing
  // ----------------------------------------------------------------
  // Spacing is judged from the second tick on.
  logic [7:0] gap;
  logic seen;
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || ctrl_tick_out)
      gap <= 8'h00;
    else
      gap <= gap + 8'h01;
    if (!rstn)
      seen <= 1'b0;
    else if (ctrl_tick_out)
      seen <= 1'b1;
  end
  tick_period_a: assert property (ctrl_tick_out && seen |-> gap == 8'h63)
    else $error("tick spacing");
  out_hold_a: assert property ($changed(torque_setpoint_out) || $changed(speed_setpoint_out)
    |-> ctrl_tick_out) else $error("output moved");
  upper_cap_a: assert property (ctrl_tick_out && !quick_stop_out && $past(upper_torque_limit_in) >= 0
    |-> torque_setpoint_out <= $past(upper_torque_limit_in)) else $error("above upper limit");
  lower_cap_a: assert property (ctrl_tick_out && !quick_stop_out && $past(lower_torque_limit_in) <= 0
    |-> torque_setpoint_out >= $past(lower_torque_limit_in)) else $error("below lower limit");
  qsp_entry_a: assert property (ctrl_tick_out && $past(quick_stop_in) |-> quick_stop_out)
    else $error("no quick stop");
  speed_clamp_a: assert property (ctrl_tick_out && !quick_stop_out && !$past(phase_enable_in)
    |-> speed_setpoint_out <= 16'sh4000 && speed_setpoint_out >= 16'shc000)
    else $error("setpoint over full");
  excit_follow_a: assert property (ctrl_tick_out && !field_weak_active_out
    && $past(field_weakening_in) >= 0 && $past(field_weakening_in) <= 16'sh4000
    |-> excitation_out == $past(field_weakening_in)) else $error("excitation wrong");
  fw_headroom_a: assert property (ctrl_tick_out && $past(voltage_headroom_lost_in)
    |-> field_weak_active_out) else $error("no field weakening");
  curlim_chop_a: assert property (current_limit_out |-> !chop_16khz_out)
    else $error("limit at 16 kHz");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("stray read data");
endmodule : smcc_core_monitor

/* File: testbench/smcc_drive_model.sv */
// Power stage stand-in: plant speed, output voltage and supply headroom.
`timescale 1ns/100ps
module smcc_drive_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ctrl_tick_out,
  input wire logic signed [15:0] speed_setpoint_out,
  input wire logic signed [15:0] volt_level,
  input wire logic headroom_lost,
  output logic signed [15:0] actual_speed_in,
  output logic signed [15:0] output_voltage_in,
  output logic voltage_headroom_lost_in
);
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      actual_speed_in <= 16'sh0000;
    else if (ctrl_tick_out)
      actual_speed_in <= speed_setpoint_out;
    output_voltage_in <= rstn ? volt_level : 16'sh0000;
    voltage_headroom_lost_in <= rstn & headroom_lost;
  end
endmodule : smcc_drive_model

/* File: testbench/tb_servo_motor_control_core.sv */
// Self-checking bench for the servo motor control core.
`timescale 1ns/100ps
module tb_servo_motor_control_core;
  logic ref_clk, rstn, reg_wr, reg_rd, pe, sts, qs, il, hd, flag, qso, fwa, c16, cl, tick, hdl;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic signed [15:0] sp, at, lo, hi, pd, pl, ls, fw, is, pa, act, ov, vl, tq, ex, so;
  logic [15:0] v1;
  int fail_count, n_tests, cyc, i;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h10, 8'h1c, 8'h28, 8'h3c};
  logic [15:0] rv [6] = '{16'h0100, 16'h0004, 16'h0010, 16'h3000, 16'h4000, 16'h0000};
  logic [15:0] lat [3] = '{16'h3000, 16'hd000, 16'h1000};
  logic [15:0] ltq [3] = '{16'h2000, 16'hf000, 16'h1000};
  logic [1:0] csel [5] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
  logic [15:0] cat [5] = '{16'h1000, 16'h1000, 16'h1000, 16'h3000, 16'h5000};
  logic [15:0] ppd [3] = '{16'h0200, 16'hfe00, 16'h0080};
  logic [15:0] ppl [3] = '{16'h0100, 16'h0100, 16'h1000};
  logic [15:0] ppa [3] = '{16'h4000, 16'h4000, 16'he000};
  logic [15:0] pso [3] = '{16'h1100, 16'h0f00, 16'h1040};
  smcc_core DUT (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .speed_setpoint_in(sp),
    .additional_torque_in(at), .lower_torque_limit_in(lo), .upper_torque_limit_in(hi),
    .phase_diff_in(pd), .phase_limit_in(pl), .lower_speed_limit_in(ls), .field_weakening_in(fw),
    .integral_set_in(is), .phase_gain_adapt_in(pa), .actual_speed_in(act), .output_voltage_in(ov),
    .voltage_headroom_lost_in(hdl), .phase_enable_in(pe), .speed_torque_switch_in(sts),
    .quick_stop_in(qs), .integral_load_in(il), .torque_setpoint_out(tq), .excitation_out(ex),
    .speed_setpoint_out(so), .speed_ctrl_at_limit_flag(flag), .quick_stop_out(qso),
    .field_weak_active_out(fwa), .chop_16khz_out(c16), .current_limit_out(cl),
    .ctrl_tick_out(tick));
  smcc_drive_model plant (.ref_clk, .rstn, .ctrl_tick_out(tick),
    .speed_setpoint_out(so), .volt_level(vl), .headroom_lost(hd), .actual_speed_in(act),
    .output_voltage_in(ov), .voltage_headroom_lost_in(hdl));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk16
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    n_tests++;
    if ((reg_rdata & m) !== e)
    begin
      fail_count++;
      $display("[ERR] reg %h expected %h seen %h", a, e, reg_rdata & m);
    end
  endtask : rd
  task automatic upd(input int n);
    repeat (n) do @(posedge ref_clk); while (tick !== 1'b1);
  endtask : upd
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Tests need about 4500 cycles.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rstn, reg_wr, reg_rd, pe, sts, qs, il, hd, reg_addr, reg_wdata} = '0;
    {sp, at, pd, pl, ls, is, vl} = '0;
    hi = 16'sh7fff;
    lo = 16'sh8001;
    fw = 16'sh4000;
    pa = 16'sh4000;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    for (i = 0; i < 6; i++) rd(ra[i], 32'hffffffff, {16'h0, rv[i]});
    wr(8'h00, 32'h0);
    $display("register defaults done");
    hi <= 16'sh2000;
    lo <= 16'shf000;
    for (i = 0; i < 3; i++)
    begin
      at <= lat[i];
      upd(2);
      chk16("torque", ltq[i], tq);
      chk16("at limit", {15'h0, i < 2}, {15'h0, flag});
    end
    $display("torque limits done");
    fw <= 16'sh2000;
    upd(2);
    chk16("excitation", 16'h2000, ex);
    chk16("scaled torque", 16'h0800, tq);
    fw <= 16'sh4000;
    vl <= 16'sh3100;
    upd(2);
    chk16("auto weakening", 16'h0001, {15'h0, fwa});
    chk16("weak excitation", 16'h3f00, ex);
    vl <= 16'sh0000;
    hd <= 1'b1;
    upd(2);
    chk16("headroom weakening", 16'h0001, {15'h0, fwa});
    hd <= 1'b0;
    hi <= 16'sh7fff;
    $display("field weakening done");
    for (i = 0; i < 5; i++)
    begin
      wr(8'h14, {30'h0, csel[i]});
      at <= cat[i];
      upd(2);
      chk16("chop 16k", {15'h0, i inside {1, 2}}, {15'h0, c16});
      chk16("current limit", {15'h0, i == 4}, {15'h0, cl});
    end
    $display("chopping done");
    at <= 16'sh0000;
    sp <= 16'sh7000;
    upd(2);
    chk16("setpoint clamp", 16'h4000, so);
    wr(8'h18, 32'h1);
    sp <= 16'shf000;
    upd(2);
    chk16("cw only", 16'h0000, so);
    wr(8'h18, 32'h0);
    upd(2);
    chk16("both ways", 16'hf000, so);
    $display("setpoint limit done");
    wr(8'h0c, 32'h100);
    sp <= 16'sh1000;
    pe <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      pd <= ppd[i];
      pl <= ppl[i];
      pa <= ppa[i];
      upd(2);
      chk16("phase sum", pso[i], so);
    end
    pe <= 1'b0;
    pd <= 16'sh0000;
    $display("phase control done");
    sp <= 16'sh0100;
    sts <= 1'b1;
    upd(2);
    rd(8'h2c, 32'h20, 32'h20);
    at <= 16'sh3000;
    hi <= 16'sh2000;
    qs <= 1'b1;
    upd(2);
    rd(8'h2c, 32'h22, 32'h02);
    chk16("limits ignored", 16'h3000, tq);
    v1 = so;
    upd(1);
    chk16("decel ramp", v1 - 16'h0010, so);
    qs <= 1'b0;
    sts <= 1'b0;
    at <= 16'sh0000;
    wr(8'h20, 32'h1);
    upd(2);
    chk16("word stop", 16'h0001, {15'h0, qso});
    wr(8'h20, 32'h0);
    upd(2);
    chk16("stop cleared", 16'h0000, {15'h0, qso});
    $display("quick stop done");
    il <= 1'b1;
    is <= 16'sh0c00;
    upd(2);
    chk16("integral preset", 16'h0c00, tq);
    $display("integral load done");
    results();
  end
endmodule : tb_servo_motor_control_core
bind smcc_core smcc_core_monitor mon (.ref_clk, .rstn, .reg_rd, .reg_rdata,
  .upper_torque_limit_in, .lower_torque_limit_in, .field_weakening_in,
  .voltage_headroom_lost_in, .phase_enable_in, .quick_stop_in, .torque_setpoint_out,
  .excitation_out, .speed_setpoint_out, .quick_stop_out, .field_weak_active_out,
  .chop_16khz_out, .current_limit_out, .ctrl_tick_out);
